// >>> rtl/spirq_core.sv
// Functional notes
// - every request output pulses high for exactly two clock periods
// - framing, parity, overrun flags stay set until software writes one
// - reload request pulses on each holding-to-shift word transfer
// - async: done request pulses at the start of the frame's last bit
// - sync: done request pulses after the frame's last bit
// - receive request pulses when a frame moves into the holding register
// - baud start pulses on start bit when three enables are set
// - baud found always pulses after the second detection character
// - with first-char enable, baud found also pulses after first character
// - baud start and baud found are ORed into one request line
// - baud detect status records which baud event happened
// - fifo, not transparent: reload follows the fill-level threshold
// - async fifo, not transparent: done follows the fill-level threshold
// - holding register takes a new word while the old one shifts
// - error request pulses with receive request on any framing, parity or overrun error
`default_nettype none
module spirq_core
   import spirq_pkg::*;
#(
   parameter int unsigned FIFO_LEVEL_W = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic tx_load,
   input wire logic tx_last_bit_start,
   input wire logic tx_last_bit_end,
   input wire logic [FIFO_LEVEL_W-1:0] tx_fifo_level,
   input wire logic rx_frame_done,
   input wire logic rx_framing_bad,
   input wire logic rx_parity_bad,
   input wire logic rx_overrun,
   input wire logic baud_start_bit,
   input wire logic baud_first_char,
   input wire logic baud_second_char,
   output logic tx_reload_irq,
   output logic tx_done_irq,
   output logic rx_frame_irq,
   output logic rx_error_irq,
   output logic baud_start_irq,
   output logic baud_found_irq,
   output logic baud_irq,
   output logic irq
);
   if (FIFO_LEVEL_W < 1 || FIFO_LEVEL_W > 16) begin : g_chk
      $error("spirq_core: FIFO_LEVEL_W out of range");
   end

   typedef struct packed {
      spirq_phase_t phase;
      logic [7:0] addr;
      logic wr;
      logic [31:0] rdata;
      logic [CTRL_W-1:0] ctrl;
      logic [2:0] errflag;
      logic [2:0] bstat;
      logic [NREQ-1:0] istat;
      logic [NREQ-1:0] imask;
      logic [FIFO_LEVEL_W-1:0] thresh;
      logic [NREQ*PCNT_W-1:0] pcnt;
      logic [NREQ-1:0] req;
      logic baud_or;
      logic irq;
   } spirq_state_t;

   spirq_state_t s;
   spirq_state_t next_s;
   logic [NREQ-1:0] ev;
   logic fifo_gate;
   logic any_err;
   logic async_mode;
   logic [PCNT_W-1:0] cnt;

   always_comb begin
      next_s = s;
      cnt = '0;
      async_mode = !s.ctrl[CTRL_SYNC];
      fifo_gate = s.ctrl[CTRL_FIFO_ON] && !s.ctrl[CTRL_TRANSP];
      any_err = rx_framing_bad || rx_parity_bad || rx_overrun;
      ev = '0;
      // word transfer, buffer frees at load
      ev[REQ_RELOAD] = tx_load &&
         (!fifo_gate || tx_fifo_level <= s.thresh);
      ev[REQ_DONE] = async_mode ?
         (tx_last_bit_start && (!fifo_gate || tx_fifo_level <= s.thresh)) :
         tx_last_bit_end;
      ev[REQ_RX] = rx_frame_done;
      ev[REQ_ERR] = rx_frame_done && any_err;
      ev[REQ_BSTART] = baud_start_bit && s.ctrl[CTRL_BAUD_ON] &&
         s.ctrl[CTRL_DET_ON] && s.ctrl[CTRL_START_ON];
      // second char always, first char when enabled
      ev[REQ_BFOUND] = baud_second_char ||
         (baud_first_char && s.ctrl[CTRL_FIRST_ON]);

      for (int i = 0; i < NREQ; i++) begin
         cnt = s.pcnt[i*PCNT_W +: PCNT_W];
         if (ev[i]) begin
            cnt = PCNT_W'(PULSE_CYCLES);
         end else if (cnt != '0) begin
            cnt = cnt - 1'b1;
         end
         next_s.pcnt[i*PCNT_W +: PCNT_W] = cnt;
         next_s.req[i] = ev[i] || (cnt != '0 && !ev[i] &&
            s.pcnt[i*PCNT_W +: PCNT_W] > PCNT_W'(1));
      end
      next_s.baud_or = next_s.req[REQ_BSTART] || next_s.req[REQ_BFOUND];

      // bus slave: address phase capture
      next_s.phase = SPIRQ_IDLE;
      if (hsel && hready && htrans[1]) begin
         next_s.phase = SPIRQ_ADDR;
         next_s.addr = haddr[7:0];
         next_s.wr = hwrite;
      end

      // sticky error flags, set wins over clear
      if (s.phase == SPIRQ_ADDR && s.wr && s.addr == OFS_ERRFLAG) begin
         next_s.errflag = s.errflag & ~hwdata[2:0];
      end
      if (rx_frame_done) begin
         next_s.errflag[ERR_FRAMING] |= rx_framing_bad;
         next_s.errflag[ERR_PARITY] |= rx_parity_bad;
         next_s.errflag[ERR_OVERRUN] |= rx_overrun;
      end

      // write decode
      if (s.phase == SPIRQ_ADDR && s.wr) begin
         if (s.addr == OFS_CTRL) begin
            next_s.ctrl = hwdata[CTRL_W-1:0];
         end else if (s.addr == OFS_IRQMASK) begin
            next_s.imask = hwdata[NREQ-1:0];
         end else if (s.addr == OFS_THRESH) begin
            next_s.thresh = hwdata[FIFO_LEVEL_W-1:0];
         end else if (s.addr == OFS_BAUDSTAT) begin
            next_s.bstat = s.bstat & ~hwdata[2:0];
         end
      end
      // baud status, set wins over clear
      if (ev[REQ_BSTART]) begin
         next_s.bstat[BST_START] = 1'b1;
      end
      if (baud_first_char && s.ctrl[CTRL_FIRST_ON]) begin
         next_s.bstat[BST_FIRST] = 1'b1;
      end
      if (baud_second_char) begin
         next_s.bstat[BST_FOUND] = 1'b1;
      end

      // read data is registered at the address phase edge
      next_s.rdata = '0;
      if (hsel && hready && htrans[1] && !hwrite) begin
         if (haddr[7:0] == OFS_CTRL) begin
            next_s.rdata[CTRL_W-1:0] = s.ctrl;
         end else if (haddr[7:0] == OFS_ERRFLAG) begin
            next_s.rdata[2:0] = s.errflag;
         end else if (haddr[7:0] == OFS_BAUDSTAT) begin
            next_s.rdata[2:0] = s.bstat;
         end else if (haddr[7:0] == OFS_IRQSTAT) begin
            next_s.rdata[NREQ-1:0] = s.istat;
         end else if (haddr[7:0] == OFS_IRQMASK) begin
            next_s.rdata[NREQ-1:0] = s.imask;
         end else if (haddr[7:0] == OFS_THRESH) begin
            next_s.rdata[FIFO_LEVEL_W-1:0] = s.thresh;
         end
      end

      // sticky irq status, cleared by read, set wins
      if (hsel && hready && htrans[1] && !hwrite &&
            haddr[7:0] == OFS_IRQSTAT) begin
         next_s.istat = '0;
      end
      next_s.istat = next_s.istat | ev;
      next_s.irq = |(next_s.istat & next_s.imask);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata = s.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign tx_reload_irq = s.req[REQ_RELOAD];
   assign tx_done_irq = s.req[REQ_DONE];
   assign rx_frame_irq = s.req[REQ_RX];
   assign rx_error_irq = s.req[REQ_ERR];
   assign baud_start_irq = s.req[REQ_BSTART];
   assign baud_found_irq = s.req[REQ_BFOUND];
   assign baud_irq = s.baud_or;
   assign irq = s.irq;

   pulse_two_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      ($rose(rx_frame_irq) && !rx_frame_done) ##1 !rx_frame_done
      |-> rx_frame_irq ##1 !rx_frame_irq)
      else $error("receive request pulse not two cycles");
   done_two_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(tx_done_irq) |=> tx_done_irq)
      else $error("done request shorter than two cycles");
   err_two_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(rx_error_irq) |=> rx_error_irq)
      else $error("error request shorter than two cycles");
   start_two_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(baud_start_irq) |=> baud_start_irq)
      else $error("baud start shorter than two cycles");
   found_two_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(baud_found_irq) |=> baud_found_irq)
      else $error("baud found shorter than two cycles");
   rx_pulse_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      rx_frame_done |=> rx_frame_irq ##1 rx_frame_irq)
      else $error("receive request missing");
   err_with_rx_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      rx_frame_done && any_err |=> rx_error_irq && rx_frame_irq)
      else $error("error request not with receive");
   err_only_rx_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      rx_error_irq |-> rx_frame_irq)
      else $error("error request without receive");
   err_sticky_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      s.errflag[ERR_FRAMING] && !(s.phase == SPIRQ_ADDR && s.wr)
      |=> s.errflag[ERR_FRAMING])
      else $error("framing flag lost");
   parity_set_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      rx_frame_done && rx_parity_bad |=> s.errflag[ERR_PARITY])
      else $error("parity flag not set");
   reload_pulse_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      tx_load && !fifo_gate |=> tx_reload_irq [*2])
      else $error("reload request missing");
   reload_gate_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      fifo_gate && tx_load && tx_fifo_level > s.thresh && !tx_reload_irq
      |=> !tx_reload_irq)
      else $error("reload request above threshold");
   done_async_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      async_mode && tx_last_bit_start && !fifo_gate |=> tx_done_irq [*2])
      else $error("async done request missing");
   done_gate_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      async_mode && fifo_gate && tx_last_bit_start &&
      tx_fifo_level > s.thresh && !tx_done_irq |=> !tx_done_irq)
      else $error("done request above threshold");
   done_sync_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      !async_mode && tx_last_bit_end |=> tx_done_irq)
      else $error("sync done request missing");
   sync_early_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      !async_mode && !tx_last_bit_end && !tx_done_irq |=> !tx_done_irq)
      else $error("sync done request without frame end");
   start_gate_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(baud_start_irq) |-> $past(s.ctrl[CTRL_START_ON]))
      else $error("baud start without enable");
   start_pulse_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      baud_start_bit && s.ctrl[CTRL_BAUD_ON] && s.ctrl[CTRL_DET_ON] &&
      s.ctrl[CTRL_START_ON] |=> baud_start_irq && s.bstat[BST_START])
      else $error("baud start missing");
   baud_or_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      baud_irq == (baud_start_irq || baud_found_irq))
      else $error("baud line not the or");
   found_pulse_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      baud_second_char |=> baud_found_irq && s.bstat[BST_FOUND])
      else $error("baud found missing");
   first_char_a: assert property (
      @(posedge sys_clk) disable iff (rst)
      baud_first_char && s.ctrl[CTRL_FIRST_ON]
      |=> baud_found_irq && s.bstat[BST_FIRST])
      else $error("first character found missing");
endmodule // spirq_core
`default_nettype wire

// >>> rtl/spirq_pkg.sv
`default_nettype none
package spirq_pkg;
   // pulse length of every request, in module clock periods
   localparam int unsigned PULSE_CYCLES = 2;
   localparam int unsigned PCNT_W = 2;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ERRFLAG = 8'h04;
   localparam logic [7:0] OFS_BAUDSTAT = 8'h08;
   localparam logic [7:0] OFS_IRQSTAT = 8'h0c;
   localparam logic [7:0] OFS_IRQMASK = 8'h10;
   localparam logic [7:0] OFS_THRESH = 8'h14;

   // control register bit positions
   localparam int unsigned CTRL_SYNC = 0;
   localparam int unsigned CTRL_FIFO_ON = 1;
   localparam int unsigned CTRL_TRANSP = 2;
   localparam int unsigned CTRL_BAUD_ON = 3;
   localparam int unsigned CTRL_DET_ON = 4;
   localparam int unsigned CTRL_START_ON = 5;
   localparam int unsigned CTRL_FIRST_ON = 6;
   localparam int unsigned CTRL_W = 7;

   // error flag bit positions
   localparam int unsigned ERR_FRAMING = 0;
   localparam int unsigned ERR_PARITY = 1;
   localparam int unsigned ERR_OVERRUN = 2;

   // baud detect status bit positions
   localparam int unsigned BST_START = 0;
   localparam int unsigned BST_FIRST = 1;
   localparam int unsigned BST_FOUND = 2;

   // request index, also the sticky status bit position
   localparam int unsigned REQ_RELOAD = 0;
   localparam int unsigned REQ_DONE = 1;
   localparam int unsigned REQ_RX = 2;
   localparam int unsigned REQ_ERR = 3;
   localparam int unsigned REQ_BSTART = 4;
   localparam int unsigned REQ_BFOUND = 5;
   localparam int unsigned NREQ = 6;

   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
   localparam logic [3:0] THRESH_RESET = 4'h0;

   typedef enum logic [1:0] {
      SPIRQ_IDLE = 2'b00,
      SPIRQ_ADDR = 2'b01
   } spirq_phase_t;
endpackage : spirq_pkg
`default_nettype wire

// >>> tb/spirq_icu_model.sv
`default_nettype none
module spirq_icu_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [6:0] req,
   output logic [7:0] flag_cnt,
   output logic [7:0] bad_width
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0][1:0] run;
   // sampled mid-cycle so registered requests are settled
   // each finished request pulse counts one pending flag in flag_cnt
   always @(negedge sys_clk or posedge rst) begin
      if (rst) begin
         run = '0;
         flag_cnt = '0;
         bad_width = '0;
      end else begin
         for (int i = 0; i < 7; i++) begin
            if (req[i]) begin
               run[i] = (run[i] == 2'd3) ? 2'd3 : run[i] + 2'd1;
            end else if (run[i] != 2'd0) begin
               flag_cnt = flag_cnt + 8'h01;
               if (run[i] != 2'd2) begin
                  bad_width = bad_width + 8'h01;
               end
               run[i] = 2'd0;
            end
         end
      end
   end
endmodule // spirq_icu_model
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import spirq_pkg::*;
   logic sys_clk, rst, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [3:0] lvl;
   logic [6:0] evr, req;
   logic [2:0] qual;
   logic [7:0] flag_cnt, bad_width, npulse;
   logic t_rl, t_dn, r_fr, r_er, b_st, b_fd, b_or;
   int err_total, cmp_count, cyc;
   assign req = {b_or, b_fd, b_st, r_er, r_fr, t_dn, t_rl};
   spirq_core spirq_core_i (.sys_clk(sys_clk), .rst(rst), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(1'b1),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tx_load(evr[0]),
      .tx_last_bit_start(evr[1]), .tx_last_bit_end(evr[2]),
      .tx_fifo_level(lvl), .rx_frame_done(evr[3]),
      .rx_framing_bad(qual[0]), .rx_parity_bad(qual[1]),
      .rx_overrun(qual[2]), .baud_start_bit(evr[4]),
      .baud_first_char(evr[5]), .baud_second_char(evr[6]),
      .tx_reload_irq(t_rl), .tx_done_irq(t_dn), .rx_frame_irq(r_fr),
      .rx_error_irq(r_er), .baud_start_irq(b_st), .baud_found_irq(b_fd),
      .baud_irq(b_or), .irq(irq));
   spirq_icu_model spirq_icu_model_i (.sys_clk(sys_clk), .rst(rst),
      .req(req), .flag_cnt(flag_cnt), .bad_width(bad_width));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic stop_test();
      if (err_total == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      // address phase holds until hready is seen at a rising edge
      do begin
         @(posedge sys_clk);
      end while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      // data phase: read data taken at the edge that ends it
      do begin
         @(posedge sys_clk);
      end while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(q, e);
      chk({31'h0, hresp}, 32'h0);
   endtask
   // one-cycle event, then request must stand exactly two cycles
   task automatic ev(input logic [6:0] e, input logic [2:0] q,
                     input logic [6:0] x);
      @(posedge sys_clk);
      evr <= e;
      qual <= q;
      @(posedge sys_clk);
      evr <= '0;
      qual <= '0;
      repeat (2) begin @(negedge sys_clk); chk({25'h0, req}, {25'h0, x}); end
      @(negedge sys_clk);
      chk({25'h0, req}, 32'h0);
      npulse = npulse + 8'($countones(x));
   endtask
   initial begin
      {rst, hwrite, htrans, haddr, hwdata, evr, qual} = '0;
      {err_total, cmp_count, cyc, npulse, lvl} = '0;
      rst = 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd(OFS_CTRL, 32'h0);
      rd(OFS_THRESH, 32'h0);
      rd(8'h18, 32'h0);
      ev(7'h01, 3'h0, 7'h01);
      ev(7'h02, 3'h0, 7'h02);
      ev(7'h04, 3'h0, 7'h00);
      wr(OFS_CTRL, 32'h1);
      ev(7'h04, 3'h0, 7'h02);
      ev(7'h02, 3'h0, 7'h00);
      wr(OFS_CTRL, 32'h0);
      ev(7'h03, 3'h0, 7'h03);
      ev(7'h08, 3'h0, 7'h04);
      for (int i = 0; i < 3; i++) begin
         ev(7'h08, 3'(1 << i), 7'h0c);
         rd(OFS_ERRFLAG, (32'h2 << i) - 32'h1);
      end
      wr(OFS_ERRFLAG, 32'h7);
      rd(OFS_ERRFLAG, 32'h0);
      ev(7'h10, 3'h0, 7'h00);
      ev(7'h40, 3'h0, 7'h60);
      ev(7'h20, 3'h0, 7'h00);
      wr(OFS_CTRL, 32'h18);
      ev(7'h10, 3'h0, 7'h00);
      wr(OFS_BAUDSTAT, 32'h7);
      wr(OFS_CTRL, 32'h78);
      ev(7'h10, 3'h0, 7'h50);
      ev(7'h20, 3'h0, 7'h60);
      rd(OFS_BAUDSTAT, 32'h3);
      ev(7'h40, 3'h0, 7'h60);
      rd(OFS_BAUDSTAT, 32'h7);
      wr(OFS_THRESH, 32'h2);
      wr(OFS_CTRL, 32'h2);
      lvl <= 4'h3;
      ev(7'h01, 3'h0, 7'h00);
      ev(7'h02, 3'h0, 7'h00);
      lvl <= 4'h2;
      ev(7'h01, 3'h0, 7'h01);
      ev(7'h02, 3'h0, 7'h02);
      wr(OFS_CTRL, 32'h6);
      lvl <= 4'h3;
      ev(7'h01, 3'h0, 7'h01);
      wr(OFS_IRQMASK, 32'h4);
      rd(OFS_IRQSTAT, 32'h3f);
      rd(OFS_IRQSTAT, 32'h0);
      @(negedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      ev(7'h08, 3'h0, 7'h04);
      chk({31'h0, irq}, 32'h1);
      ev(7'h01, 3'h0, 7'h01);
      rd(OFS_IRQSTAT, 32'h5);
      @(negedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      chk({24'h0, flag_cnt}, {24'h0, npulse});
      chk({24'h0, bad_width}, 32'h0);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
